// File: core/mrp_pkg.sv
// constants, types and the vector priority table of the motion result output port
// assumes one 125 MHz clock; the distortion producer and sequence timing live elsewhere
package mrp_pkg;

  // sequence timing, in cycles counted from the sequence's first cycle (cycle 1)
  localparam logic [5:0] MRP_CYC_FIRST     = 6'h01;
  localparam logic [5:0] MRP_CYC_MAX       = 6'h3F;
  localparam logic [5:0] MRP_M_SHORT       = 6'h08;  // 8 pixel high reference block
  localparam logic [5:0] MRP_M_TALL        = 6'h10;  // 16 pixel high reference block
  localparam logic [5:0] MRP_STORE_OFS     = 6'h01;  // set stored at cycle M+1
  localparam logic [5:0] MRP_SEARCH_OFS    = 6'h02;  // first search cycle M+2
  localparam logic [5:0] MRP_SEARCH_CYCLES = 6'h1C;  // 28 search cycles
  localparam logic [5:0] MRP_LAST_OFS      = MRP_SEARCH_OFS + MRP_SEARCH_CYCLES - 6'h01;
  localparam logic [8:0] MRP_SEARCH_LANES  = 9'h00A; // entries compared per cycle
  localparam int         MRP_LANES         = 10;
  localparam logic [8:0] MRP_ENTRIES       = 9'h100; // 256 candidate vectors

  // register map (byte addresses, low address byte decoded)
  localparam logic [7:0] MRP_REG_CTRL   = 8'h00;
  localparam logic [7:0] MRP_REG_STATUS = 8'h04;
  localparam logic [7:0] MRP_REG_RESULT = 8'h08;
  // control fields
  localparam int MRP_CTRL_RD_DIS  = 0;  // refuse distortion reads
  localparam int MRP_CTRL_SKIP    = 1;  // skip delivery of meaningless results
  localparam logic [1:0] MRP_CTRL_RST = 2'h0;
  // status fields
  localparam int MRP_ST_VALID  = 0;
  localparam int MRP_ST_BUSY   = 1;
  localparam int MRP_ST_PEND   = 2;
  localparam int MRP_ST_BANK   = 3;
  localparam int MRP_ST_EDGE   = 4;  // four bits: left, bottom, right, top
  localparam int MRP_RES_MV    = 16; // vector byte above the 16-bit minimum
  localparam logic [15:0] MRP_DIST_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    MRP_IDLE  = 3'b000,
    MRP_PEND  = 3'b001,  // result ready, waiting for or driving the vector
    MRP_GAP   = 3'b010,
    MRP_HI    = 3'b011,
    MRP_LO    = 3'b100,
    MRP_RD_HI = 3'b101,
    MRP_RD_LO = 3'b110
  } mrp_ostate_e;

  // frame-edge pins, highest bit first
  typedef struct packed {
    logic left_edge_input;
    logic bottom_edge_input;
    logic right_edge_input;
    logic top_edge_input;
  } mrp_edge_s;

  // distortion write from the computing array, same clock
  typedef struct packed {
    logic        en;
    logic [7:0]  addr;  // vector code: horizontal high nibble, vertical low nibble
    logic [15:0] data;
  } mrp_dwr_s;

  typedef struct packed {
    mrp_ostate_e ostate;
    logic        seq_run;
    logic [5:0]  seq_cnt;
    logic        m_tall;
    logic        cur_block;
    logic        prev_block;
    logic        meaningful;
    logic        bank;
    mrp_edge_s   edge_cur;
    mrp_edge_s   edge_prev;
    mrp_edge_s   edge_s1;
    mrp_edge_s   edge_s2;
    logic        oe_s1;
    logic        oe_s2;
    logic        oe_d;
    logic [7:0]  bus_s1;
    logic [7:0]  bus_s2;
    logic [15:0] best_d;
    logic [7:0]  best_p;
    logic [7:0]  best_a;
    logic        best_f;
    logic [7:0]  mv;
    logic [15:0] min_d;
    logic [7:0]  rd_addr;
    logic [15:0] rd_data;
    logic [1:0]  ctrl;
    logic        ahb_wr;
    logic [7:0]  ahb_addr;
    logic [31:0] hrdata;
  } mrp_state_s;

  // enable sync stages start high: a pin already high at reset is no read request
  localparam mrp_state_s MRP_STATE_RST = '{ostate: MRP_IDLE, oe_s1: 1'b1, oe_s2: 1'b1,
                                          oe_d: 1'b1, default: '0};

  // tie priority: row = vertical -8..7, column = horizontal -8..7
  localparam logic [0:15][0:15][7:0] MRP_PRIO = {
    128'h020C1E3A5A7A9ABABB9B7B5B3B1F0D03,
    128'h0006142A4A6A8AAAAB8B6B4B2B150701,
    128'h08162C4C6C8CACCACBAD8D6D4D2D1709,
    128'h040E203C5C7C9CBCBD9D7D5D3D210F05,
    128'h1228486888A8C8E2E3C9A98969492913,
    128'h0A1C38587898B8D6D7B9997959391D0B,
    128'h1A36567696B6D4ECEDD5B7977757371B,
    128'h1026466686A6C6E0E1C7A78767472711,
    128'h24446484A4C4DEF4FFDFC5A585654525,
    128'h1834547494B4D2EAEBD3B59575553519,
    128'h32527292B2D0E8F9FAE9D1B393735333,
    128'h22426282A2C2DCF2F3DDC3A383634323,
    128'h406080A0C0DAF0FDFEF1DBC1A1816141,
    128'h30507090B0CEE6F7F8E7CFB191715131,
    128'h3E5E7E9EBED8EEFBFCEFD9BF9F7F5F3F,
    128'h2E4E6E8EAECCE4F5F6E5CDAF8F6F4F2F
  };

  function automatic logic [7:0] mrp_prio(input logic [7:0] code);
    mrp_prio = MRP_PRIO[{~code[3], code[2:0]}][{~code[7], code[6:4]}];
  endfunction : mrp_prio

  // vector allowed under the latched edge restrictions
  function automatic logic mrp_edge_ok(input logic [7:0] code, input mrp_edge_s e);
    logic v_zero;
    logic h_zero;
    v_zero = (code[3:0] == 4'h0);
    h_zero = (code[7:4] == 4'h0);
    mrp_edge_ok = !(e.top_edge_input    && code[3])
               && !(e.bottom_edge_input && !code[3] && !v_zero)
               && !(e.left_edge_input   && code[7])
               && !(e.right_edge_input  && !code[7] && !h_zero);
  endfunction : mrp_edge_ok

endpackage : mrp_pkg

// File: core/mrp_result_port.sv
// motion result output port: minimum search, result delivery, distortion reads, edge control
// assumes seq_start/seq_is_block/seq_m_tall/dist_wr come from logic on hclk;
// output_enable, result_bus_in and edge pins come from outside and are synchronised here
//
// Summary of operation
// (R01) each sequence start triggers minimum search and address
// (R02) results meaningful only after a block sequence
// (R03) result-ready strobe low in cycle M+30
// (R04) vector driven one cycle, then idle cycle
// (R05) high byte with its strobe, then low byte
// (R06) output enable drop abandons remaining bytes
// (R07) enable low: bus released, strobe held low
// (R08) next sequence start discards pending results
// (R09) ties resolved by fixed priority table
// (R10) vector byte: horizontal high nibble, vertical low
// (R11) minimum is 16-bit, high byte first
// (R12) no distortion reads during minimum search
// (R13) controller puts address with enable low
// (R14) address is last value sampled enable-low
// (R15) dead cycle, then high and low bytes
// (R16) distortion address equals vector code
// (R17) store at M+1, search 28, deliver 4
// (R18) edge pins latched in first block cycle
// (R19) top/bottom restrict vertical sign
// (R20) right/left restrict horizontal sign
// (R21) edge restrictions combine by intersection
// (R22) no edges: all 256 vectors considered
// (R23) controller sets block height at sync strobe
// (R24) controller opens initialization with sync strobe
// (R25) one 16-bit entry per vector code
// (R26) bus driven only while enabled and delivering
`timescale 1ns/10ps

module mrp_result_port (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // sequence timing from the pipeline control
  input  wire logic                seq_start,
  input  wire logic                seq_is_block,
  input  wire logic                seq_m_tall,
  input  wire mrp_pkg::mrp_dwr_s   dist_wr,
  // frame-edge pins
  input  wire mrp_pkg::mrp_edge_s  edge_pins,
  // result bus pins
  input  wire logic                output_enable,
  input  wire logic [7:0]          result_bus_in,
  output logic [7:0]               result_bus_out,
  output logic                     result_bus_oe,
  output logic                     result_ready_strobe_n,
  output logic                     dist_high_byte_strobe_n,
  output logic                     dist_low_byte_strobe_n
);

  mrp_pkg::mrp_state_s r;
  mrp_pkg::mrp_state_s s;

  // two banks: one being filled by the array, one searched and read
  logic [15:0] dist_mem [0:1][0:255];  // R25

  logic [5:0]  m_val;
  logic [5:0]  cur_cycle;
  logic        run;
  logic        store_now;
  logic        search_now;
  logic        last_search;
  logic        busy;
  logic        rd_block;
  logic [5:0]  scan_step;
  logic [8:0]  lidx;
  logic [7:0]  la;
  logic [15:0] ld;
  logic [7:0]  lp;
  logic        oe;
  logic        rd_rise;
  logic        ahb_take;

  // sequence position; M is taken from the block height of the running sequence
  always_comb begin
    m_val       = r.m_tall ? mrp_pkg::MRP_M_TALL : mrp_pkg::MRP_M_SHORT;
    cur_cycle   = seq_start ? mrp_pkg::MRP_CYC_FIRST : r.seq_cnt;
    run         = r.seq_run || seq_start;
    store_now   = run && (cur_cycle == m_val + mrp_pkg::MRP_STORE_OFS);  // R17
    search_now  = run && (cur_cycle >= m_val + mrp_pkg::MRP_SEARCH_OFS)
                      && (cur_cycle <= m_val + mrp_pkg::MRP_LAST_OFS);
    last_search = run && (cur_cycle == m_val + mrp_pkg::MRP_LAST_OFS);
    busy        = run && (cur_cycle >= m_val + mrp_pkg::MRP_STORE_OFS)
                      && (cur_cycle <= m_val + mrp_pkg::MRP_LAST_OFS);
    // a read taken from cycle M on would still strobe once the search runs
    rd_block    = run && (cur_cycle >= m_val)
                      && (cur_cycle <= m_val + mrp_pkg::MRP_LAST_OFS);
    scan_step   = cur_cycle - (m_val + mrp_pkg::MRP_SEARCH_OFS);
    oe          = r.oe_s2;
    rd_rise     = oe && !r.oe_d;
    ahb_take    = hsel && htrans[1] && hready;
  end

  // next-state logic for the whole block
  always_comb begin
    s    = r;
    lidx = '0;
    la   = '0;
    ld   = '0;
    lp   = '0;
    // synchronisers: the first stage feeds only the second
    s.oe_s1   = output_enable;
    s.oe_s2   = r.oe_s1;
    s.oe_d    = r.oe_s2;
    s.bus_s1  = result_bus_in;
    s.bus_s2  = r.bus_s1;
    s.edge_s1 = edge_pins;
    s.edge_s2 = r.edge_s1;

    // sequence counter saturates so a stalled pipeline raises no events
    if (seq_start) begin
      s.seq_run    = 1'b1;
      s.m_tall     = seq_m_tall;
      s.prev_block = r.cur_block;
      s.cur_block  = seq_is_block;
      s.edge_prev  = r.edge_cur;
      if (seq_is_block) begin
        s.edge_cur = r.edge_s2;  // R18
      end
    end
    if (run && cur_cycle != mrp_pkg::MRP_CYC_MAX) begin
      s.seq_cnt = cur_cycle + mrp_pkg::MRP_CYC_FIRST;
    end

    // store: swap banks so the finished set becomes the searched one
    if (store_now) begin
      s.bank       = ~r.bank;  // R17
      s.meaningful = s.prev_block;  // R02
      s.best_f     = 1'b0;
      s.best_d     = mrp_pkg::MRP_DIST_MAX;
      s.best_p     = '0;
      s.best_a     = '0;
    end

    // parallel compare lanes; ties go to the higher table priority
    for (int k = 0; k < mrp_pkg::MRP_LANES; k++) begin
      lidx = 9'({3'h0, scan_step} * mrp_pkg::MRP_SEARCH_LANES) + 9'(k);
      la   = lidx[7:0];
      ld   = dist_mem[r.bank][la];
      lp   = mrp_pkg::mrp_prio(la);
      if (search_now && lidx < mrp_pkg::MRP_ENTRIES
          && mrp_pkg::mrp_edge_ok(la, r.edge_prev)) begin  // R19 R20 R21 R22
        if (!s.best_f || ld < s.best_d || (ld == s.best_d && lp > s.best_p)) begin  // R01 R09
          s.best_f = 1'b1;
          s.best_d = ld;
          s.best_p = lp;
          s.best_a = la;
        end
      end
    end

    // delivery and read sequencer
    unique case (r.ostate)
      mrp_pkg::MRP_IDLE: begin
        if (!oe) begin
          s.rd_addr = r.bus_s2;  // R14
        end
        // the rising cycle itself is the dead cycle
        if (rd_rise && !rd_block && !r.ctrl[mrp_pkg::MRP_CTRL_RD_DIS]) begin  // R12
          s.rd_data = dist_mem[r.bank][r.rd_addr];  // R16
          s.ostate  = mrp_pkg::MRP_RD_HI;  // R15
        end
      end
      mrp_pkg::MRP_PEND: begin
        if (seq_start) begin
          s.ostate = mrp_pkg::MRP_IDLE;  // R08
        end else if (oe) begin
          s.ostate = mrp_pkg::MRP_GAP;  // R04
        end
      end
      mrp_pkg::MRP_GAP: begin
        s.ostate = oe ? mrp_pkg::MRP_HI : mrp_pkg::MRP_IDLE;  // R06
      end
      mrp_pkg::MRP_HI: begin
        s.ostate = oe ? mrp_pkg::MRP_LO : mrp_pkg::MRP_IDLE;  // R05 R06
      end
      mrp_pkg::MRP_LO: begin
        s.ostate = mrp_pkg::MRP_IDLE;
      end
      mrp_pkg::MRP_RD_HI: begin
        s.ostate = oe ? mrp_pkg::MRP_RD_LO : mrp_pkg::MRP_IDLE;
      end
      mrp_pkg::MRP_RD_LO: begin
        s.ostate = mrp_pkg::MRP_IDLE;
      end
      default: begin
        s.ostate = mrp_pkg::MRP_IDLE;
      end
    endcase

    // end of search: results take the bus from cycle M+30 on
    if (last_search) begin
      s.mv    = s.best_a;
      s.min_d = s.best_d;
      if (r.ctrl[mrp_pkg::MRP_CTRL_SKIP] && !r.meaningful) begin
        s.ostate = mrp_pkg::MRP_IDLE;
      end else begin
        s.ostate = mrp_pkg::MRP_PEND;  // R03
      end
    end

    // ahb-lite: zero wait states, read data registered in the address phase
    s.ahb_wr = ahb_take && hwrite;
    if (ahb_take) begin
      s.ahb_addr = haddr[7:0];
    end
    if (r.ahb_wr && r.ahb_addr == mrp_pkg::MRP_REG_CTRL) begin
      s.ctrl = hwdata[1:0];
    end
    if (ahb_take && !hwrite) begin
      s.hrdata = '0;
      unique case (haddr[7:0])
        mrp_pkg::MRP_REG_CTRL: begin
          s.hrdata[1:0] = s.ctrl;
        end
        mrp_pkg::MRP_REG_STATUS: begin
          s.hrdata[mrp_pkg::MRP_ST_VALID]     = r.meaningful;
          s.hrdata[mrp_pkg::MRP_ST_BUSY]      = busy;
          s.hrdata[mrp_pkg::MRP_ST_PEND]      = (r.ostate == mrp_pkg::MRP_PEND);
          s.hrdata[mrp_pkg::MRP_ST_BANK]      = r.bank;
          s.hrdata[mrp_pkg::MRP_ST_EDGE +: 4] = r.edge_prev;
        end
        mrp_pkg::MRP_REG_RESULT: begin
          s.hrdata[15:0]                    = r.min_d;
          s.hrdata[mrp_pkg::MRP_RES_MV +: 8] = r.mv;
        end
        default: begin
          s.hrdata = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= mrp_pkg::MRP_STATE_RST;
    end else begin
      r <= s;
    end
  end

  // distortion banks need no reset; the array writes the idle bank only
  always_ff @(posedge hclk) begin
    if (dist_wr.en) begin
      dist_mem[~r.bank][dist_wr.addr] <= dist_wr.data;  // R25
    end
  end

  // pin drive: byte strobes and bus follow the synchronised output enable; the ready strobe does not
  always_comb begin
    result_ready_strobe_n   = (r.ostate != mrp_pkg::MRP_PEND);  // R03 R07
    dist_high_byte_strobe_n = !(oe && (r.ostate == mrp_pkg::MRP_HI
                                    || r.ostate == mrp_pkg::MRP_RD_HI));  // R05
    dist_low_byte_strobe_n  = !(oe && (r.ostate == mrp_pkg::MRP_LO
                                    || r.ostate == mrp_pkg::MRP_RD_LO));  // R05
    result_bus_oe  = oe && (r.ostate == mrp_pkg::MRP_PEND || r.ostate == mrp_pkg::MRP_HI
                         || r.ostate == mrp_pkg::MRP_LO || r.ostate == mrp_pkg::MRP_RD_HI
                         || r.ostate == mrp_pkg::MRP_RD_LO);  // R26 R07
    unique case (r.ostate)
      mrp_pkg::MRP_PEND:  result_bus_out = r.mv;            // R10
      mrp_pkg::MRP_HI:    result_bus_out = r.min_d[15:8];   // R11
      mrp_pkg::MRP_LO:    result_bus_out = r.min_d[7:0];    // R11
      mrp_pkg::MRP_RD_HI: result_bus_out = r.rd_data[15:8];
      mrp_pkg::MRP_RD_LO: result_bus_out = r.rd_data[7:0];
      default:            result_bus_out = '0;
    endcase
    hreadyout = 1'b1;
    hresp     = 1'b0;
    hrdata    = r.hrdata;
  end

endmodule : mrp_result_port

// File: verification/mrp_result_port_assertions.sv
// pin-level assertions for the motion result output port
// assumes binding onto mrp_result_port and a single clock domain
`timescale 1ns/10ps
module mrp_assert_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sequence timing
  input wire logic seq_start,
  input wire logic seq_m_tall,
  // result bus pins
  input wire logic output_enable,
  input wire logic result_bus_oe,
  input wire logic result_ready_strobe_n,
  input wire logic dist_high_byte_strobe_n,
  input wire logic dist_low_byte_strobe_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [8:0] cyc_r;
  logic       m_r;
  logic [8:0] cur;
  logic [8:0] m_v;
  // cycle number in the sequence; saturates so long sequences stay quiet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_r <= 9'h1FF;
      m_r   <= 1'b0;
    end else if (seq_start) begin
      cyc_r <= 9'h002;
      m_r   <= seq_m_tall;
    end else if (cyc_r != 9'h1FF) begin
      cyc_r <= cyc_r + 9'h001;
    end
  end
  assign cur = seq_start ? 9'h001 : cyc_r;
  assign m_v = m_r ? 9'h010 : 9'h008;
  // the pin reaches the logic late, so look back three cycles
  sequence s_off;
    !output_enable && !$past(output_enable) && !$past(output_enable, 2)
      && !$past(output_enable, 3);
  endsequence
  sequence s_vec;
    !result_ready_strobe_n && result_bus_oe;
  endsequence
  sequence s_gap;
    result_ready_strobe_n && !result_bus_oe && dist_high_byte_strobe_n;
  endsequence
  AST_VEC_THEN_GAP: assert property (s_vec |=> s_gap)
    else $error("vector cycle not followed by a quiet cycle");
  AST_HI_BYTE: assert property (!dist_high_byte_strobe_n |->
      result_bus_oe && dist_low_byte_strobe_n ##1 dist_high_byte_strobe_n)
    else $error("high byte strobe malformed");
  AST_LO_AFTER_HI: assert property ($fell(dist_low_byte_strobe_n) |->
      !$past(dist_high_byte_strobe_n) && result_bus_oe)
    else $error("low byte not right after high byte");
  AST_READY_TIME: assert property ($fell(result_ready_strobe_n) |->
      cur == m_v + 9'h01E)
    else $error("result ready strobe fell at wrong cycle");
  AST_NO_READ_IN_SEARCH: assert property (cur >= m_v + 9'h002 &&
      cur <= m_v + 9'h01D |-> dist_high_byte_strobe_n && dist_low_byte_strobe_n)
    else $error("byte strobe during minimum search");
  AST_BUS_NEEDS_OE: assert property (result_bus_oe |-> output_enable ||
      $past(output_enable) || $past(output_enable, 2) || $past(output_enable, 3))
    else $error("bus driven without enable");
  AST_HOLD_WHILE_OFF: assert property (
      !result_ready_strobe_n && !seq_start ##0 s_off |=> !result_ready_strobe_n)
    else $error("ready strobe released while disabled");
  AST_DROP_ON_NEW_SEQ: assert property (
      seq_start && !result_ready_strobe_n ##0 s_off |=> result_ready_strobe_n)
    else $error("pending results kept past new sequence");
endmodule : mrp_assert_chk

bind mrp_result_port mrp_assert_chk u_chk (
  .hclk(hclk), .hresetn(hresetn), .seq_start(seq_start), .seq_m_tall(seq_m_tall),
  .output_enable(output_enable), .result_bus_oe(result_bus_oe),
  .result_ready_strobe_n(result_ready_strobe_n),
  .dist_high_byte_strobe_n(dist_high_byte_strobe_n),
  .dist_low_byte_strobe_n(dist_low_byte_strobe_n));

// File: verification/mrp_ctrl_model.sv
// system controller model on the shared result bus
// assumes the device's split bus pins and one clock
`timescale 1ns/10ps
module mrp_ctrl_model (
  // clock
  input wire logic        hclk,
  // device side of the bus
  input wire logic [7:0]  result_bus_out,
  input wire logic        result_bus_oe,
  input wire logic        result_ready_strobe_n,
  input wire logic        dist_high_byte_strobe_n,
  input wire logic        dist_low_byte_strobe_n,
  // controller drives
  output logic            output_enable,
  output logic [7:0]      result_bus_in
);
  logic [7:0]  addr_r = 8'h00;
  logic        drv_r = 1'b0;
  logic [7:0]  last_r = 8'h00;
  logic [7:0]  mv_got = 8'h00;
  logic [15:0] dist_got = 16'h0000;
  int          mv_cnt = 0;
  int          lo_cnt = 0;
  initial output_enable = 1'b1;
  // a released bus shows the inverse of its last level, never a stale value
  assign result_bus_in = result_bus_oe ? result_bus_out : drv_r ? addr_r : ~last_r;
  // capture what the device puts out under each strobe
  always @(posedge hclk) begin
    last_r <= result_bus_in;
    if (!result_ready_strobe_n && result_bus_oe) begin
      mv_got <= result_bus_out;
      mv_cnt <= mv_cnt + 1;
    end
    if (!dist_high_byte_strobe_n && result_bus_oe) dist_got[15:8] <= result_bus_out;
    if (!dist_low_byte_strobe_n && result_bus_oe) begin
      dist_got[7:0] <= result_bus_out;
      lo_cnt <= lo_cnt + 1;
    end
  end
  task automatic set_oe(input logic v);
    output_enable <= v;
  endtask : set_oe
  // address stands with enable low until sampled, then enable rises
  task automatic read_dist(input logic [7:0] a, output logic [15:0] d, output logic ok);
    int c0;
    addr_r <= a;
    drv_r <= 1'b1;
    output_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    output_enable <= 1'b1;
    drv_r <= 1'b0;
    c0 = lo_cnt;
    ok = 1'b0;
    repeat (8) begin
      @(posedge hclk);
      if (lo_cnt != c0) ok = 1'b1;
    end
    d = dist_got;
  endtask : read_dist
endmodule : mrp_ctrl_model

// File: verification/motion_result_output_port_test.sv
// self-checking bench for the motion result output port
// assumes the controller model on the result bus and an ahb-lite master here
`timescale 1ns/10ps
module motion_result_output_port_test;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic seq_start = 1'b0, seq_is_block = 1'b0, next_blk = 1'b0, run = 1'b0, ok;
  logic seq_m_tall = 1'b0;
  mrp_pkg::mrp_dwr_s dist_wr = '0;
  mrp_pkg::mrp_edge_s edge_pins = '0, next_edge = '0;
  logic oe, bus_oe, rdy_n, hi_n, lo_n;
  logic [7:0] bus_in, bus_out;
  logic [15:0] wmem [256];
  logic [15:0] d;
  int seq_idx = -1, cyc = 288, tick = 0, fails = 0, check_count = 0, n0;
  always #4 hclk = ~hclk;
  mrp_result_port uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .seq_start(seq_start), .seq_is_block(seq_is_block),
    .seq_m_tall(seq_m_tall), .dist_wr(dist_wr), .edge_pins(edge_pins),
    .output_enable(oe), .result_bus_in(bus_in), .result_bus_out(bus_out),
    .result_bus_oe(bus_oe), .result_ready_strobe_n(rdy_n),
    .dist_high_byte_strobe_n(hi_n), .dist_low_byte_strobe_n(lo_n));
  mrp_ctrl_model ctl (.hclk(hclk), .result_bus_out(bus_out), .result_bus_oe(bus_oe),
    .result_ready_strobe_n(rdy_n), .dist_high_byte_strobe_n(hi_n),
    .dist_low_byte_strobe_n(lo_n), .output_enable(oe), .result_bus_in(bus_in));
  // back to back sequences of 288 cycles, each writing one set from cycle 10
  always @(posedge hclk) begin
    int n;
    n = (cyc == 288) ? 1 : cyc + 1;
    edge_pins <= next_edge;
    if (run) begin
      cyc <= n;
      seq_start <= (n == 1);
      if (n == 1) begin
        seq_idx <= seq_idx + 1;
        seq_is_block <= next_blk;
      end
      dist_wr.en <= (n >= 10) && (n < 266);
      dist_wr.addr <= 8'(n - 10);
      dist_wr.data <= wmem[8'(n - 10)];
    end
  end
  // hang guard, well above the six sequences used
  always @(posedge hclk) begin
    tick <= tick + 1;
    if (tick == 6000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_at(input int k, input int c);
    while (!(seq_idx == k && cyc == c)) @(posedge hclk);
  endtask : wait_at
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb
  task automatic fill(input logic [15:0] v);
    for (int i = 0; i < 256; i++) wmem[i] = v;
  endtask : fill
  task automatic t_regs;
    ahb(1'b0, mrp_pkg::MRP_REG_CTRL, 32'h0, r);
    check(r, 32'h0);
    check({hreadyout, hresp}, 2'h2);
    ahb(1'b1, mrp_pkg::MRP_REG_CTRL, 32'h3, r);
    ahb(1'b0, mrp_pkg::MRP_REG_CTRL, 32'h0, r);
    check(r, 32'h3);
    ahb(1'b1, mrp_pkg::MRP_REG_CTRL, 32'h0, r);
    ahb(1'b0, 8'h0C, 32'h0, r);
    check(r, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // tied minimum at zero vector and at (1,1); top edge armed for the next set
  task automatic t_tie;
    next_blk = 1'b1;
    wait_at(1, 1);
    fill(16'h0400);
    wmem[8'h00] = 16'h0123;
    wmem[8'h11] = 16'h0123;
    wait_at(1, 50);
    ahb(1'b0, mrp_pkg::MRP_REG_STATUS, 32'h0, r);
    check(r & 32'h1, 32'h0);
    wait_at(1, 200);
    next_edge.top_edge_input = 1'b1;
    wait_at(2, 1);
    fill(16'h0500);
    wmem[8'h0F] = 16'h0010;
    wmem[8'h01] = 16'h0020;
    wmem[8'h10] = 16'h0020;
    n0 = ctl.mv_cnt;
    wait_at(2, 50);
    check(ctl.mv_cnt - n0, 1);
    check(ctl.mv_got, 8'h00);
    check(ctl.dist_got, 16'h0123);
    ahb(1'b0, mrp_pkg::MRP_REG_STATUS, 32'h0, r);
    check(r & 32'h1, 32'h1);
    $display("test tie done");
  endtask : t_tie
  // delivery held back by low enable, then distortion reads by vector code
  task automatic t_hold;
    wait_at(2, 200);
    next_edge = '0;
    wait_at(3, 30);
    ctl.set_oe(1'b0);
    n0 = ctl.mv_cnt;
    wait_at(3, 60);
    check({rdy_n, bus_oe}, 2'b00);
    check(ctl.mv_cnt, n0);
    ctl.set_oe(1'b1);
    wait_at(3, 70);
    check(ctl.mv_got, 8'h01);
    check(ctl.dist_got, 16'h0020);
    ahb(1'b0, mrp_pkg::MRP_REG_RESULT, 32'h0, r);
    check(r, 32'h00010020);
    ahb(1'b0, mrp_pkg::MRP_REG_STATUS, 32'h0, r);
    check(r & 32'hF1, 32'h11);
    ctl.read_dist(8'h10, d, ok);
    check({ok, d}, 17'h10020);
    ctl.read_dist(8'h0F, d, ok);
    check({ok, d}, 17'h10010);
    ahb(1'b1, mrp_pkg::MRP_REG_CTRL, 32'h1, r);
    ctl.read_dist(8'h10, d, ok);
    check(ok, 1'b0);
    ahb(1'b1, mrp_pkg::MRP_REG_CTRL, 32'h0, r);
    $display("test hold done");
  endtask : t_hold
  // results dropped at the next start, busy read refused, left plus right edges
  task automatic t_drop;
    wait_at(3, 200);
    next_edge.left_edge_input = 1'b1;
    next_edge.right_edge_input = 1'b1;
    wait_at(4, 1);
    fill(16'h0600);
    wmem[8'h10] = 16'h0001;
    wmem[8'h03] = 16'h0030;
    wait_at(4, 30);
    ctl.set_oe(1'b0);
    n0 = ctl.mv_cnt;
    wait_at(5, 5);
    check(rdy_n, 1'b1);
    wait_at(5, 8);
    ctl.read_dist(8'h03, d, ok);
    check(ok, 1'b0);
    check(ctl.mv_cnt, n0);
    wait_at(5, 60);
    check(ctl.mv_got, 8'h03);
    check(ctl.dist_got, 16'h0030);
    $display("test drop done");
  endtask : t_drop
  initial begin
    fill(16'h0400);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    run <= 1'b1;
    t_regs();
    t_tie();
    t_hold();
    t_drop();
    stop_test();
  end
endmodule : motion_result_output_port_test
